// File: verilog/pbo_pkg.sv
package pbo_pkg;

    // Width of the port and the pin index of each shared function.
    localparam int PIN_COUNT = 8;
    localparam int PIN_MISO  = 0;
    localparam int PIN_MOSI  = 1;
    localparam int PIN_EXT_IRQ1_LINE  = 2;
    localparam int PIN_AMP0N = 3;
    localparam int PIN_AMP0P = 4;
    localparam int PIN_EXT_IRQ2_LINE  = 5;
    localparam int PIN_PWM1B = 6;
    localparam int PIN_SCK   = 7;

    // Values after reset of the input sampling chain.
    localparam logic [7:0] SYNC_RST = 8'h00;
    localparam logic [7:0] READ_RST = 8'h00;

    // Number of flip-flops between a pad and the settled read value.
    localparam int SYNC_STAGES = 3;

    // All state of the top module: three sampling stages and the settled value.
    typedef struct packed {
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [7:0] sync3;
        logic [7:0] read;
    } pbo_state_type;

endpackage : pbo_pkg

// File: verilog/pbo_pin_ctl.sv
module pbo_pin_ctl (
    // Port register bits of this pin.
    input  wire logic dir_bit_in,
    input  wire logic out_bit_in,
    input  wire logic global_pullup_disable_in,
    input  wire logic sleep_in,
    // Override pairs from the alternate functions.
    input  wire logic pullup_ovr_en_in,
    input  wire logic pullup_ovr_val_in,
    input  wire logic dir_ovr_en_in,
    input  wire logic dir_ovr_val_in,
    input  wire logic portval_ovr_en_in,
    input  wire logic portval_ovr_val_in,
    input  wire logic din_en_ovr_en_in,
    input  wire logic din_en_ovr_val_in,
    // Resolved pad controls.
    output logic      pullup_on_out,
    output logic      drv_en_out,
    output logic      drv_val_out,
    output logic      din_en_out
);

    // Pure gates, so a change of any control bit reaches the pad at once.
    always_comb
    begin
        if (pullup_ovr_en_in)
        begin
            pullup_on_out = pullup_ovr_val_in;
        end
        else
        begin
            pullup_on_out = ~dir_bit_in & out_bit_in & ~global_pullup_disable_in;
        end
        drv_en_out = dir_ovr_en_in ? dir_ovr_val_in : dir_bit_in;
        // The pad shows a low level when not driven, never an unknown one.
        if (drv_en_out)
        begin
            drv_val_out = portval_ovr_en_in ? portval_ovr_val_in : out_bit_in;
        end
        else
        begin
            drv_val_out = 1'b0;
        end
        din_en_out = din_en_ovr_en_in ? din_en_ovr_val_in : ~sleep_in;
    end

endmodule : pbo_pin_ctl

// File: verilog/pbo_port_b_override.sv
// What this block does
// - SPI slave forces pin 1 to input.
// - SPI master: pin 1 follows its direction bit unless PWM 2B is on.
// - SPI master forces pin 0 to input.
// - SPI slave: pin 0 follows its direction bit unless PWM 2A is on.
// - Forced inputs keep pull-up from port bit.
// - Pin 7 direction from SPI slave and PWM 0B.
// - Pin 7 value from PWM 0B or SPI.
// - SPI clock input gated by pin-set and reset.
// - SPI pin 1 input gated by pin-set, reset.
// - SPI pin 0 input gated by pin-set, reset.
// - Pin 5 input enable from ADC6, interrupt 2.
// - Pin 2 input enable from ADC5, interrupt 1.
// - Pin 6 driven by PWM 1B when enabled.
// - Amplifier 0 disable kills pins 4, 3 input.
// - ADC disable bits kill pins 7,6 input, and pins 5,2 unless their interrupt is on.
// - Pin n feeds pin-change source n.
// - Pull-up follows override or 010 pattern.
// - Driver enable follows override or direction bit.
// - Driven value follows override or port bit.
// - Input enable follows override or sleep state.
module pbo_port_b_override (
    // Clock and resets.
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       internal_reset_in,
    input  wire logic       sleep_in,
    // Port register bits.
    input  wire logic [7:0] dir_bits_in,
    input  wire logic [7:0] out_bits_in,
    input  wire logic       global_pullup_disable_in,
    // SPI controls and the values the SPI drives out.
    input  wire logic       spi_on_in,
    input  wire logic       spi_master_sel_in,
    input  wire logic       spi_pin_set_sel_in,
    input  wire logic       spi_clk_drive_in,
    input  wire logic       spi_mosi_drive_in,
    input  wire logic       spi_miso_drive_in,
    // PWM output enables and levels.
    input  wire logic       pwm_out0b_en_in,
    input  wire logic       pwm_out0b_level_in,
    input  wire logic       pwm_out1b_en_in,
    input  wire logic       pwm_out1b_level_in,
    input  wire logic       pwm_out2a_en_in,
    input  wire logic       pwm_out2a_level_in,
    input  wire logic       pwm_out2b_en_in,
    input  wire logic       pwm_out2b_level_in,
    // External interrupt enables.
    input  wire logic       ext_irq1_en_in,
    input  wire logic       ext_irq2_en_in,
    // Analog digital-input disables.
    input  wire logic       adc_ch4_din_off_in,
    input  wire logic       adc_ch5_din_off_in,
    input  wire logic       adc_ch6_din_off_in,
    input  wire logic       adc_ch7_din_off_in,
    input  wire logic       amp0_din_off_in,
    // Pads.
    input  wire logic [7:0] pad_in,
    output logic      [7:0] pad_out,
    output logic      [7:0] pad_oe_out,
    output logic      [7:0] pad_pullup_out,
    // Digital inputs towards the core and the peripherals.
    output logic      [7:0] port_read_out,
    output logic      [7:0] pin_change_src_out,
    output logic            ext_irq1_line_out,
    output logic            ext_irq2_line_out,
    output logic            spi_clk_pin_input_out,
    output logic            spi_mosi_pin_input_out,
    output logic            spi_miso_pin_input_out
);

    // Registered state and its next value.
    // Only the input path holds state; the overrides are gates.
    pbo_pkg::pbo_state_type st_r;
    pbo_pkg::pbo_state_type st_nxt;

    // Override pairs, one bit per pin.
    // Bit n belongs to pin n; bits of pins without such a
    // function stay at zero.
    logic [7:0] pullup_ovr_en;
    logic [7:0] pullup_ovr_val;
    logic [7:0] dir_ovr_en;
    logic [7:0] dir_ovr_val;
    logic [7:0] portval_ovr_en;
    logic [7:0] portval_ovr_val;
    logic [7:0] din_en_ovr_en;
    logic [7:0] din_en_ovr_val;

    // Resolved pad controls from the per-pin cells.
    // These are final once every override is applied.
    logic [7:0] drv_en;
    logic [7:0] drv_val;
    logic [7:0] pullup_on;
    logic [7:0] din_en;

    // SPI mode terms on the default pin set.
    // Slave and master never hold together.
    logic       spi_slave;
    logic       spi_master;
    logic       spi_in_gate;

    // The SPI owns pins 7, 1 and 0 only while the default pin set is chosen.
    // On the other pin set these terms drop to zero and the pins
    // fall back to port or PWM control.
    assign spi_slave   = spi_on_in & ~spi_master_sel_in & ~spi_pin_set_sel_in;
    assign spi_master  = spi_on_in & spi_master_sel_in & ~spi_pin_set_sel_in;
    assign spi_in_gate = ~spi_pin_set_sel_in & ~internal_reset_in;

    // Override terms; all are gates on the live control bits.
    // Every bit starts at zero, so a pin without a function acts
    // as a plain port pin and no latch is inferred.
    always_comb
    begin
        pullup_ovr_en   = 8'h00;
        pullup_ovr_val  = 8'h00;
        dir_ovr_en      = 8'h00;
        dir_ovr_val     = 8'h00;
        portval_ovr_en  = 8'h00;
        portval_ovr_val = 8'h00;
        din_en_ovr_en   = 8'h00;
        din_en_ovr_val  = 8'h00;

        // Pin 7: SPI clock, PWM output 0B and ADC channel 4.
        // As a slave input its pull-up stays under the port bit
        // and the global disable, as on the data pins.
        pullup_ovr_en[pbo_pkg::PIN_SCK]  = spi_slave;
        pullup_ovr_val[pbo_pkg::PIN_SCK] = out_bits_in[pbo_pkg::PIN_SCK]
                                           & ~global_pullup_disable_in;

        // A live PWM output takes the pin in any SPI mode.
        dir_ovr_en[pbo_pkg::PIN_SCK]     = spi_slave | pwm_out0b_en_in;
        dir_ovr_val[pbo_pkg::PIN_SCK]    = pwm_out0b_en_in;

        portval_ovr_en[pbo_pkg::PIN_SCK] = spi_master | pwm_out0b_en_in;
        // The PWM level wins over the SPI clock, so a live PWM is never chopped.
        portval_ovr_val[pbo_pkg::PIN_SCK] = (pwm_out0b_level_in & pwm_out0b_en_in)
                                            | (spi_clk_drive_in & ~pwm_out0b_en_in
                                               & ~spi_pin_set_sel_in);

        // A cut analog input wins over sleep.
        din_en_ovr_en[pbo_pkg::PIN_SCK]  = adc_ch4_din_off_in;
        din_en_ovr_val[pbo_pkg::PIN_SCK] = 1'b0;

        // Pin 6: PWM output 1B and ADC channel 7.
        // No SPI function shares this pin, so the PWM needs no
        // priority term.
        dir_ovr_en[pbo_pkg::PIN_PWM1B]      = pwm_out1b_en_in;
        dir_ovr_val[pbo_pkg::PIN_PWM1B]     = 1'b1;
        portval_ovr_en[pbo_pkg::PIN_PWM1B]  = pwm_out1b_en_in;
        portval_ovr_val[pbo_pkg::PIN_PWM1B] = pwm_out1b_level_in;

        din_en_ovr_en[pbo_pkg::PIN_PWM1B]   = adc_ch7_din_off_in;
        din_en_ovr_val[pbo_pkg::PIN_PWM1B]  = 1'b0;

        // Pin 5: interrupt 2 keeps the input alive even in sleep.
        // An ADC disable alone cuts the input; an enabled interrupt
        // keeps it on, so a wake-up edge is still seen.
        din_en_ovr_en[pbo_pkg::PIN_EXT_IRQ2_LINE]  = adc_ch6_din_off_in | ext_irq2_en_in;
        din_en_ovr_val[pbo_pkg::PIN_EXT_IRQ2_LINE] = ext_irq2_en_in;

        // Pins 4 and 3: amplifier 0 inputs.
        // One disable bit serves both; software must switch the
        // pull-up off on an analog pin.
        din_en_ovr_en[pbo_pkg::PIN_AMP0P]  = amp0_din_off_in;
        din_en_ovr_val[pbo_pkg::PIN_AMP0P] = 1'b0;

        din_en_ovr_en[pbo_pkg::PIN_AMP0N]  = amp0_din_off_in;
        din_en_ovr_val[pbo_pkg::PIN_AMP0N] = 1'b0;

        // Pin 2: interrupt 1 keeps the input alive even in sleep.
        // Same trade as on pin 5.
        din_en_ovr_en[pbo_pkg::PIN_EXT_IRQ1_LINE]  = adc_ch5_din_off_in | ext_irq1_en_in;
        din_en_ovr_val[pbo_pkg::PIN_EXT_IRQ1_LINE] = ext_irq1_en_in;

        // Pin 1: SPI data, input as slave, output as master.
        pullup_ovr_en[pbo_pkg::PIN_MOSI]  = spi_slave;
        pullup_ovr_val[pbo_pkg::PIN_MOSI] = out_bits_in[pbo_pkg::PIN_MOSI]
                                            & ~global_pullup_disable_in;

        // Without an override the pin keeps its direction bit as master.
        dir_ovr_en[pbo_pkg::PIN_MOSI]     = spi_slave | pwm_out2b_en_in;
        // A slave never drives here, even with the PWM output switched on.
        dir_ovr_val[pbo_pkg::PIN_MOSI]    = pwm_out2b_en_in & ~spi_slave;

        // The PWM level wins over the master data, as on pin 7.
        portval_ovr_en[pbo_pkg::PIN_MOSI] = spi_master | pwm_out2b_en_in;
        portval_ovr_val[pbo_pkg::PIN_MOSI] = pwm_out2b_en_in ? pwm_out2b_level_in
                                                             : spi_mosi_drive_in;

        // Pin 0: SPI data, input as master, output as slave.
        pullup_ovr_en[pbo_pkg::PIN_MISO]  = spi_master;
        pullup_ovr_val[pbo_pkg::PIN_MISO] = out_bits_in[pbo_pkg::PIN_MISO]
                                            & ~global_pullup_disable_in;

        // As master the pin is an input even with the PWM on.
        dir_ovr_en[pbo_pkg::PIN_MISO]     = spi_master | pwm_out2a_en_in;
        dir_ovr_val[pbo_pkg::PIN_MISO]    = pwm_out2a_en_in & ~spi_master;

        // A slave drives its reply here unless the PWM owns the pin.
        portval_ovr_en[pbo_pkg::PIN_MISO] = spi_slave | pwm_out2a_en_in;
        portval_ovr_val[pbo_pkg::PIN_MISO] = pwm_out2a_en_in ? pwm_out2a_level_in
                                                             : spi_miso_drive_in;
    end

    // One resolving cell per pin; no flip-flop sits on this path.
    // The cells are identical, so a change to the resolving rules
    // is made once and holds for every pin.
    // A pin that gains a function only needs its override pair.
    genvar gi;
    generate
        for (gi = 0; gi < pbo_pkg::PIN_COUNT; gi++)
        begin : g_pin
            pbo_pin_ctl u_pin (
                .dir_bit_in               (dir_bits_in[gi]),
                .out_bit_in               (out_bits_in[gi]),
                .global_pullup_disable_in (global_pullup_disable_in),
                .sleep_in                 (sleep_in),
                .pullup_ovr_en_in         (pullup_ovr_en[gi]),
                .pullup_ovr_val_in        (pullup_ovr_val[gi]),
                .dir_ovr_en_in            (dir_ovr_en[gi]),
                .dir_ovr_val_in           (dir_ovr_val[gi]),
                .portval_ovr_en_in        (portval_ovr_en[gi]),
                .portval_ovr_val_in       (portval_ovr_val[gi]),
                .din_en_ovr_en_in         (din_en_ovr_en[gi]),
                .din_en_ovr_val_in        (din_en_ovr_val[gi]),
                .pullup_on_out            (pullup_on[gi]),
                .drv_en_out               (drv_en[gi]),
                .drv_val_out              (drv_val[gi]),
                .din_en_out               (din_en[gi])
            );
        end
    endgenerate

    // Pad controls leave the block without a register.
    // This adds no cycle at the pad, at the price of short
    // glitches while several control bits change together.
    assign pad_out        = drv_val;
    assign pad_oe_out     = drv_en;
    assign pad_pullup_out = pullup_on;

    // Sampling chain; an enabled input's settled value only moves when stages two and three agree.
    // Stage one may go metastable and is never compared; a pulse
    // shorter than one period never reaches the settled value.
    // The settled value is the only one the core sees.
    always_comb
    begin
        st_nxt       = st_r;
        // The three stages shift one place on every edge.
        st_nxt.sync1 = pad_in;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.sync3 = st_r.sync2;

        // Each pin settles on its own.
        for (int i = 0; i < pbo_pkg::PIN_COUNT; i++)
        begin
            // A disabled input reads low, so a floating analog pad draws no current.
            if (!din_en[i])
            begin
                st_nxt.read[i] = 1'b0;
            end
            // An enabled input moves only when the last two stages
            // agree; otherwise it keeps its settled level.
            else if (st_r.sync2[i] == st_r.sync3[i])
            begin
                st_nxt.read[i] = st_r.sync3[i];
            end
        end
    end

    // State register.
    // The asynchronous reset clears the chain with no clock running.
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            // Every stage and the read value clear together.
            st_r.sync1 <= pbo_pkg::SYNC_RST;
            st_r.sync2 <= pbo_pkg::SYNC_RST;
            st_r.sync3 <= pbo_pkg::SYNC_RST;
            st_r.read  <= pbo_pkg::READ_RST;
        end
        else
        begin
            // The whole state moves in one step.
            st_r <= st_nxt;
        end
    end

    // Digital inputs to the core and to the interrupt logic.
    // They see the filtered value, so a disabled input can never
    // raise an interrupt.
    assign port_read_out      = st_r.read;
    assign pin_change_src_out = st_r.read;
    assign ext_irq1_line_out  = st_r.read[pbo_pkg::PIN_EXT_IRQ1_LINE];
    assign ext_irq2_line_out  = st_r.read[pbo_pkg::PIN_EXT_IRQ2_LINE];

    // SPI inputs are held low on the other pin set and during internal reset.
    // This keeps a stray pad edge from clocking the SPI while it is
    // routed elsewhere or held in reset.
    assign spi_clk_pin_input_out  = st_r.read[pbo_pkg::PIN_SCK] & spi_in_gate;
    assign spi_mosi_pin_input_out = st_r.read[pbo_pkg::PIN_MOSI] & spi_in_gate;
    assign spi_miso_pin_input_out = st_r.read[pbo_pkg::PIN_MISO] & spi_in_gate;

endmodule : pbo_port_b_override

// File: testbench/pbo_port_b_override_checker.sv
module pbo_port_b_override_checker (
    // Clock and reset.
    input  wire logic       clk_in, rst_b_in,
    // Controls watched.
    input  wire logic       internal_reset_in, sleep_in, global_pullup_disable_in,
    input  wire logic       spi_on_in, spi_master_sel_in, spi_pin_set_sel_in,
    input  wire logic       pwm_out0b_en_in, pwm_out0b_level_in,
    input  wire logic       pwm_out1b_en_in, pwm_out1b_level_in,
    input  wire logic       amp0_din_off_in, adc_ch4_din_off_in,
    input  wire logic [7:0] out_bits_in, pad_in,
    // Outputs watched.
    input  wire logic [7:0] pad_out, pad_oe_out, pad_pullup_out,
    input  wire logic [7:0] port_read_out, pin_change_src_out,
    input  wire logic       ext_irq1_line_out, ext_irq2_line_out,
    input  wire logic       spi_clk_pin_input_out, spi_mosi_pin_input_out, spi_miso_pin_input_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    // The SPI claims pins only while pin-set select leaves it on this port.
    sequence spi_slave_s;
        spi_on_in && !spi_master_sel_in && !spi_pin_set_sel_in;
    endsequence
    sequence spi_master_s;
        spi_on_in && spi_master_sel_in && !spi_pin_set_sel_in;
    endsequence
    // Two edges cover the settle of the registered read after an input is switched off.
    sequence amp0_off_s;
        amp0_din_off_in [*2];
    endsequence
    sequence pad3_held_s;
        (!sleep_in && !amp0_din_off_in && $stable(pad_in[3])) [*5];
    endsequence
    slave_pin1_a : assert property (
        spi_slave_s |-> !pad_oe_out[1] && pad_pullup_out[1] == (out_bits_in[1] && !global_pullup_disable_in))
        else $error("pin 1 not forced to input with port pull-up");
    master_pin0_a : assert property (
        spi_master_s |-> !pad_oe_out[0] && pad_pullup_out[0] == (out_bits_in[0] && !global_pullup_disable_in))
        else $error("pin 0 not forced to input with port pull-up");
    pin7_pwm_a : assert property (
        pwm_out0b_en_in |-> pad_oe_out[7] && pad_out[7] == pwm_out0b_level_in)
        else $error("pin 7 not driven by pwm output 0b");
    pin7_slave_a : assert property (
        spi_slave_s and !pwm_out0b_en_in |-> !pad_oe_out[7])
        else $error("pin 7 driven while spi is slave");
    pin6_pwm_a : assert property (
        pwm_out1b_en_in |-> pad_oe_out[6] && pad_out[6] == pwm_out1b_level_in)
        else $error("pin 6 not driven by pwm output 1b");
    spi_gate_a : assert property (
        {spi_clk_pin_input_out, spi_mosi_pin_input_out, spi_miso_pin_input_out} ==
        ({port_read_out[7], port_read_out[1:0]} & {3{!spi_pin_set_sel_in && !internal_reset_in}}))
        else $error("spi pin inputs not gated");
    pin_mirror_a : assert property (
        pin_change_src_out == port_read_out && ext_irq1_line_out == port_read_out[2]
        && ext_irq2_line_out == port_read_out[5])
        else $error("pin change or interrupt lines differ from read");
    amp0_off_a : assert property (
        amp0_off_s |-> port_read_out[4:3] == 2'h0)
        else $error("amplifier pins still read with input disabled");
    adc4_off_a : assert property (
        adc_ch4_din_off_in [*2] |-> !port_read_out[7])
        else $error("pin 7 still read with input disabled");
    pad_settle_a : assert property (
        pad3_held_s |-> port_read_out[3] == pad_in[3])
        else $error("pin 3 read did not settle to the pad");
endmodule : pbo_port_b_override_checker

bind pbo_port_b_override pbo_port_b_override_checker pbo_port_b_override_checker_inst (.*);

// File: testbench/pbo_pad_partner.sv
module pbo_pad_partner (
    // Clock.
    input  wire logic       clk_in,
    // What the port drives and asks for.
    input  wire logic [7:0] pad_out_in,
    input  wire logic [7:0] pad_oe_in,
    input  wire logic [7:0] pad_pullup_in,
    // Board drivers.
    input  wire logic [7:0] ext_drive_in,
    input  wire logic [7:0] ext_val_in,
    // Resolved pad level.
    output logic      [7:0] pad_level_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] last_r = 8'h00;
    // A pad nobody drives and no pull-up holds keeps flipping, so it never reads as a kind value.
    always_comb
    begin
        pad_level_out = (pad_oe_in & pad_out_in) | (~pad_oe_in & ext_drive_in & ext_val_in)
                      | (~pad_oe_in & ~ext_drive_in & (pad_pullup_in | ~last_r));
    end
    // Last level, the seed of the flipping pattern.
    always_ff @(posedge clk_in)
    begin
        last_r <= pad_level_out;
    end
endmodule : pbo_pad_partner

// File: testbench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    // One expected result: which output, the value and the bits that are pinned down.
    typedef struct {int sel; logic [7:0] e; logic [7:0] m;} pbo_note_type;
    logic         clk_in   = 1'b0;
    logic         rst_b_in = 1'b0;
    logic  [23:0] ctl      = 24'h000000;
    logic  [7:0]  dir      = 8'h00;
    logic  [7:0]  outb     = 8'h00;
    logic  [7:0]  xdrv     = 8'h00;
    logic  [7:0]  xval     = 8'h00;
    logic  [7:0]  pad, po, poe, ppu, rd, pcs, exp_rd, msk_rd;
    logic         irq1, irq2, sck, mosi, miso;
    pbo_note_type notes[$];
    pbo_note_type n;
    int           failures = 0;
    int           comparisons = 0;
    int           seed = 78;
    int           cycles = 0;
    string        sel_name[6] = '{"pad_oe", "pad_out", "pad_pullup", "read", "pin_change", "spi_irq"};
    // Control bits travel in one vector so one random draw sets them all.
    pbo_port_b_override pbo_port_b_override_inst (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .internal_reset_in(ctl[0]), .sleep_in(ctl[1]),
        .dir_bits_in(dir), .out_bits_in(outb), .global_pullup_disable_in(ctl[2]),
        .spi_on_in(ctl[3]), .spi_master_sel_in(ctl[4]), .spi_pin_set_sel_in(ctl[5]),
        .spi_clk_drive_in(ctl[6]), .spi_mosi_drive_in(ctl[7]), .spi_miso_drive_in(ctl[8]),
        .pwm_out0b_en_in(ctl[9]), .pwm_out0b_level_in(ctl[10]), .pwm_out1b_en_in(ctl[11]),
        .pwm_out1b_level_in(ctl[12]), .pwm_out2a_en_in(ctl[13]), .pwm_out2a_level_in(ctl[14]),
        .pwm_out2b_en_in(ctl[15]), .pwm_out2b_level_in(ctl[16]), .ext_irq1_en_in(ctl[17]),
        .ext_irq2_en_in(ctl[18]), .adc_ch4_din_off_in(ctl[19]), .adc_ch5_din_off_in(ctl[20]),
        .adc_ch6_din_off_in(ctl[21]), .adc_ch7_din_off_in(ctl[22]), .amp0_din_off_in(ctl[23]),
        .pad_in(pad), .pad_out(po), .pad_oe_out(poe), .pad_pullup_out(ppu), .port_read_out(rd),
        .pin_change_src_out(pcs), .ext_irq1_line_out(irq1), .ext_irq2_line_out(irq2),
        .spi_clk_pin_input_out(sck), .spi_mosi_pin_input_out(mosi), .spi_miso_pin_input_out(miso)
    );
    pbo_pad_partner pbo_pad_partner_inst (
        .clk_in(clk_in), .pad_out_in(po), .pad_oe_in(poe), .pad_pullup_in(ppu),
        .ext_drive_in(xdrv), .ext_val_in(xval), .pad_level_out(pad)
    );
    // Clock of 100 ns.
    always #50 clk_in = ~clk_in;
    task automatic final_report();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    task automatic note(input int sel, input logic [7:0] e, input logic [7:0] m);
        notes.push_back('{sel, e, m});
    endtask : note
    task automatic check(input string name, input logic [7:0] e, input logic [7:0] s);
        comparisons++;
        if (s !== e)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, e, s);
        end
    endtask : check
    function automatic logic [7:0] observe(input int sel);
        case (sel)
            0: return poe;
            1: return po;
            2: return ppu;
            3: return rd;
            4: return pcs;
            default: return {3'h0, sck, mosi, miso, irq2, irq1};
        endcase
    endfunction : observe
    // Drive one setting; pads are noted at once, reads once the sampling chain has settled.
    // Bits whose value is the designer's open choice are left out of the mask.
    task automatic run_case(input logic [23:0] c, input logic [7:0] d, o, xd, xv);
        logic [7:0] oe, v, pu, mo, mv, mp, din;
        logic       slv, mst;
        slv = c[3] & ~c[4] & ~c[5];
        mst = c[3] & c[4] & ~c[5];
        oe = d;
        v = o;
        pu = ~d & o & {8{~c[2]}};
        {mo, mv, mp} = {24{1'b1}};
        if (c[9]) {oe[7], v[7]} = {1'b1, c[10]};
        else if (slv) oe[7] = 1'b0;
        else if (mst) v[7] = c[6];
        if (slv) pu[7] = o[7] & ~c[2];
        if (c[11]) {oe[6], v[6]} = {1'b1, c[12]};
        if (c[3] & c[5]) {mo[1:0], mv[1:0], mp[1:0]} = 6'h00;
        if (slv) {oe[1], pu[1]} = {1'b0, o[1] & ~c[2]};
        else if (c[15]) {mo[1], mv[1]} = 2'h0;
        else if (mst) v[1] = c[7];
        if (mst) {oe[0], pu[0]} = {1'b0, o[0] & ~c[2]};
        else if (c[13]) {mo[0], mv[0]} = 2'h0;
        else if (slv) v[0] = c[8];
        v = v & oe;
        mv = mv & mo;
        din = {8{~c[1]}};
        if (c[19]) din[7] = 1'b0;
        if (c[22]) din[6] = 1'b0;
        if (c[21] | c[18]) din[5] = c[18];
        if (c[23]) din[4:3] = 2'h0;
        if (c[20] | c[17]) din[2] = c[17];
        exp_rd = din & ((oe & v) | (~oe & ((xd & xv) | (~xd & pu))));
        msk_rd = (mv & mp & (oe | xd | pu)) | ~din;
        {ctl, dir, outb} <= {c, d, o};
        {xdrv, xval} <= {xd, xv};
        note(0, oe, mo);
        note(1, v, mv);
        note(2, pu, mp);
        repeat (6) @(posedge clk_in);
        note(3, exp_rd, msk_rd);
        note(4, exp_rd, msk_rd);
        note(5, {3'h0, {exp_rd[7], exp_rd[1:0]} & {3{~c[5] & ~c[0]}}, exp_rd[5], exp_rd[2]},
             {3'h0, msk_rd[7], msk_rd[1:0], msk_rd[5], msk_rd[2]});
        // The gated SPI inputs are compared before the next setting lands.
        @(posedge clk_in);
    endtask : run_case
    // Noted results are compared in order once the outputs settle at the falling edge.
    always @(negedge clk_in)
    begin
        while (notes.size() > 0)
        begin
            n = notes.pop_front();
            check(sel_name[n.sel], n.e & n.m, observe(n.sel) & n.m);
        end
    end
    // A hang is cut short; the whole run needs some 500 cycles.
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles > 2000)
        begin
            failures++;
            final_report();
        end
    end
    // Reset, random settings with every SPI mode, then directed cases and a second reset.
    initial
    begin
        logic [23:0] c;
        repeat (4) @(posedge clk_in);
        note(3, 8'h00, 8'hff);
        @(posedge clk_in);
        rst_b_in <= 1'b1;
        for (int i = 0; i < 64; i++)
        begin
            c = 24'($random(seed));
            c[5:3] = i[2:0];
            run_case(c, 8'($random(seed)), 8'($random(seed)), 8'($random(seed)), 8'($random(seed)));
        end
        $display("test random settings done");
        run_case(24'h800000, 8'h00, 8'he7, 8'hff, 8'hff);
        run_case(24'h000000, 8'h00, 8'hff, 8'h00, 8'h00);
        rst_b_in <= 1'b0;
        @(posedge clk_in);
        note(3, 8'h00, 8'hff);
        note(5, 8'h00, 8'hff);
        @(posedge clk_in);
        rst_b_in <= 1'b1;
        run_case(24'h000000, 8'h00, 8'h00, 8'hff, 8'h5a);
        $display("test directed cases and second reset done");
        final_report();
    end
endmodule : testbench
